// >>> src/scs_defs.svh
// Constants for the scanner channel selector
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
`define SCS_CLK_HZ        20000000
`define SCS_TICK_CYCLES   ((`SCS_CLK_HZ) / 1000)
`define SCS_MS_PER_SEC    10'h3e8
`define SCS_DWELL_MAX     7'h63
`define SCS_SETTLE_US     5
`define SCS_SETTLE_CYCLES (((`SCS_SETTLE_US) * (`SCS_CLK_HZ) + 999999) / 1000000)
`define SCS_CHAN_LAST     3'h4
`define SCS_CHAN_RESET    3'h0
`define SCS_ADDR_CTRL     4'h0
`define SCS_ADDR_STAT     4'h1
`define SCS_ADDR_DWELL0   4'h2
`define SCS_CTRL_SCAN     0
`define SCS_CTRL_ADV      1
`define SCS_CTRL_DIRECT   2
`define SCS_CTRL_SEL_LO   4
`define SCS_CTRL_SEL_HI   6
`define SCS_STAT_BUSY     3
`define SCS_STAT_IDSW     4
`endif

// >>> src/scs_pkg.sv
// Types for the scanner channel selector
package scs_pkg;
  typedef logic [2:0] scs_chan_t;
  typedef enum logic [1:0] {
    SCS_IDLE,
    SCS_MAKE,
    SCS_BREAK,
    SCS_OPEN
  } scs_seq_e;
endpackage : scs_pkg

// >>> src/scs_dwell_timer.sv
// Dwell timer counting whole seconds from milliseconds it divides down from clk_sys
`timescale 1ns/1ns
`include "scs_defs.svh"
module scs_dwell_timer
  import scs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       restart,
  input  wire logic       run,
  input  wire logic [6:0] dwellSec,
  output logic            expired
);
  logic [14:0] tickCnt;
  logic [14:0] next_tickCnt;
  logic [9:0]  msCnt;
  logic [9:0]  next_msCnt;
  logic [6:0]  secCnt;
  logic [6:0]  next_secCnt;
  logic        next_expired;

  always_comb begin
    next_tickCnt = tickCnt;
    next_msCnt   = msCnt;
    next_secCnt  = secCnt;
    next_expired = 1'b0;
    if (restart || !run) begin
      next_tickCnt = '0;
      next_msCnt   = '0;
      next_secCnt  = '0;
    end else if (secCnt >= dwellSec) begin
      next_expired = 1'b1;
      next_secCnt  = '0;
    end else if (tickCnt == 15'((`SCS_TICK_CYCLES) - 1)) begin
      next_tickCnt = '0;
      if (msCnt == `SCS_MS_PER_SEC - 10'h001) begin
        next_msCnt  = '0;
        next_secCnt = secCnt + 7'h01;
      end else begin
        next_msCnt = msCnt + 10'h001;
      end
    end else begin
      next_tickCnt = tickCnt + 15'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tickCnt <= '0;
      msCnt   <= '0;
      secCnt  <= '0;
      expired <= 1'b0;
    end else begin
      tickCnt <= next_tickCnt;
      msCnt   <= next_msCnt;
      secCnt  <= next_secCnt;
      expired <= next_expired;
    end
  end
endmodule : scs_dwell_timer

// >>> src/scs_relay_seq.sv
// Relay pole sequencer: current make-before-break, voltage break-before-make
`timescale 1ns/1ns
`include "scs_defs.svh"
module scs_relay_seq
  import scs_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst,
  input  wire logic      change,
  input  scs_chan_t      newChan,
  output logic [4:0]     curPoles,
  output logic [4:0]     voltPoles,
  output logic           busy
);
  localparam int SETTLE = `SCS_SETTLE_CYCLES;
  scs_seq_e    state;
  scs_seq_e    next_state;
  scs_chan_t   target;
  scs_chan_t   next_target;
  logic [4:0]  next_curPoles;
  logic [4:0]  next_voltPoles;
  logic [17:0] waitCnt;
  logic [17:0] next_waitCnt;

  function automatic logic [4:0] onehot(input scs_chan_t ch);
    onehot = 5'h01 << ch;
  endfunction : onehot

  always_comb begin
    next_state     = state;
    next_target    = target;
    next_curPoles  = curPoles;
    next_voltPoles = voltPoles;
    next_waitCnt   = (waitCnt != '0) ? waitCnt - 18'h00001 : waitCnt;
    case (state)
      SCS_IDLE: begin
        if (change) begin
          next_target = newChan;
          next_curPoles = curPoles | onehot(newChan);
          next_voltPoles = '0;
          next_waitCnt   = 18'(SETTLE);
          next_state     = SCS_MAKE;
        end
      end
      SCS_MAKE: begin
        if (waitCnt == '0) begin
          next_curPoles = onehot(target);
          next_waitCnt  = 18'(SETTLE);
          next_state    = SCS_BREAK;
        end
      end
      SCS_BREAK: begin
        if (waitCnt == '0) begin
          next_voltPoles = onehot(target);
          next_state     = SCS_OPEN;
        end
      end
      default: next_state = SCS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= SCS_IDLE;
      target    <= `SCS_CHAN_RESET;
      curPoles  <= 5'h01;
      voltPoles <= 5'h01;
      waitCnt   <= '0;
      busy      <= 1'b0;
    end else begin
      state     <= next_state;
      target    <= next_target;
      curPoles  <= next_curPoles;
      voltPoles <= next_voltPoles;
      waitCnt   <= next_waitCnt;
      busy      <= (next_state != SCS_IDLE);
    end
  end
endmodule : scs_relay_seq

// >>> src/scs_channel_select.sv
// Top of the five-way sensor scanner channel selector
`timescale 1ns/1ns
`include "scs_defs.svh"
module scs_channel_select
  import scs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       keyAdvance,
  input  wire logic       idSwitchBit4,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  output logic            chan_code_lsb,
  output logic            chan_code_mid,
  output logic            chan_code_msb,
  output logic      [2:0] displayChan,
  output logic      [2:0] curvePos,
  output logic            curvePosValid,
  output logic      [4:0] currentPoles,
  output logic      [4:0] voltagePoles
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic keyMeta;
  logic keySync;
  logic keyLast;
  logic idMeta;
  logic idSync;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keyMeta <= 1'b0;
      keySync <= 1'b0;
      keyLast <= 1'b0;
      idMeta  <= 1'b0;
      idSync  <= 1'b0;
    end else begin
      keyMeta <= keyAdvance;
      keySync <= keyMeta;
      keyLast <= keySync;
      idMeta  <= idSwitchBit4;
      idSync  <= idMeta;
    end
  end

  wire keyPress = keySync & ~keyLast;

  //////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic       scanEn;
  logic       next_scanEn;
  logic [6:0] dwell [0:4];
  logic [6:0] next_dwell [0:4];
  logic       remAdvance;
  logic       remDirect;
  scs_chan_t  remChan;

  function automatic scs_chan_t advance(input scs_chan_t ch);
    advance = (ch == `SCS_CHAN_LAST) ? `SCS_CHAN_RESET : ch + 3'h1;
  endfunction : advance

  function automatic logic [6:0] clampDwell(input logic [7:0] v);
    clampDwell = (v > 8'(`SCS_DWELL_MAX)) ? `SCS_DWELL_MAX : v[6:0];
  endfunction : clampDwell

  always_comb begin
    next_scanEn = scanEn;
    for (int i = 0; i < 5; i++) begin
      next_dwell[i] = dwell[i];
    end
    remAdvance = 1'b0;
    remDirect  = 1'b0;
    remChan    = regWdata[`SCS_CTRL_SEL_HI:`SCS_CTRL_SEL_LO];
    if (regWrite) begin
      if (regAddr == `SCS_ADDR_CTRL) begin
        next_scanEn = regWdata[`SCS_CTRL_SCAN];
        remAdvance  = regWdata[`SCS_CTRL_ADV];
        remDirect   = regWdata[`SCS_CTRL_DIRECT] && (remChan <= `SCS_CHAN_LAST);
      end else if (regAddr >= `SCS_ADDR_DWELL0 && regAddr < `SCS_ADDR_DWELL0 + 4'h5) begin
        next_dwell[3'(regAddr - `SCS_ADDR_DWELL0)] = clampDwell(regWdata);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scanEn <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        dwell[i] <= '0;
      end
    end else begin
      scanEn <= next_scanEn;
      for (int i = 0; i < 5; i++) begin
        dwell[i] <= next_dwell[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel selection
  scs_chan_t  selChan;
  scs_chan_t  next_selChan;
  logic       change;
  logic       dwellDone;
  logic       relayBusy;

  always_comb begin
    next_selChan = selChan;
    change       = 1'b0;
    if (relayBusy) begin
      next_selChan = selChan;
    end else if (remDirect) begin
      next_selChan = remChan;
      change       = (remChan != selChan);
    end else if (keyPress || remAdvance || (scanEn && dwellDone && !relayBusy)) begin
      next_selChan = advance(selChan);
      change       = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      selChan <= `SCS_CHAN_RESET;
    end else begin
      selChan <= next_selChan;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dwell timing and relay sequencing
  // hold for dwell
  scs_dwell_timer u_timer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .restart  (change),
    .run      (scanEn && !relayBusy),
    .dwellSec (dwell[selChan]),
    .expired  (dwellDone)
  );

  logic [4:0] curPolesInt;
  logic [4:0] voltPolesInt;

  scs_relay_seq u_relay (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .change    (change),
    .newChan   (next_selChan),
    .curPoles  (curPolesInt),
    .voltPoles (voltPolesInt),
    .busy      (relayBusy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic [7:0] next_regRdata;

  always_comb begin
    next_regRdata = 8'h00;
    if (regRead) begin
      if (regAddr == `SCS_ADDR_CTRL) begin
        next_regRdata = {1'b0, selChan, 3'h0, scanEn};
      end else if (regAddr == `SCS_ADDR_STAT) begin
        next_regRdata = {3'h0, idSync, relayBusy, selChan};
      end else if (regAddr >= `SCS_ADDR_DWELL0 && regAddr < `SCS_ADDR_DWELL0 + 4'h5) begin
        next_regRdata = {1'b0, dwell[3'(regAddr - `SCS_ADDR_DWELL0)]};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdata      <= 8'h00;
      chan_code_lsb <= 1'b0;
      chan_code_mid <= 1'b0;
      chan_code_msb <= 1'b0;
      displayChan   <= `SCS_CHAN_RESET;
      curvePos      <= `SCS_CHAN_RESET;
      curvePosValid <= 1'b0;
      currentPoles  <= 5'h00;
      voltagePoles  <= 5'h00;
    end else begin
      regRdata      <= next_regRdata;
      chan_code_lsb <= selChan[0];
      chan_code_mid <= selChan[1];
      chan_code_msb <= selChan[2];
      displayChan   <= selChan;
      curvePos      <= selChan;
      curvePosValid <= ~idSync;
      currentPoles  <= curPolesInt;
      voltagePoles  <= voltPolesInt;
    end
  end
endmodule : scs_channel_select

// >>> verification/scs_channel_select_assertions.sv
// Port checker for the scanner channel selector
`timescale 1ns/1ns
module scs_channel_select_checker
  import scs_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       idSwitchBit4,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       chan_code_lsb,
  input wire logic       chan_code_mid,
  input wire logic       chan_code_msb,
  input wire logic [2:0] displayChan,
  input wire logic [2:0] curvePos,
  input wire logic       curvePosValid,
  input wire logic [4:0] currentPoles,
  input wire logic [4:0] voltagePoles
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_code_bits_order: assert property (
    {chan_code_msb, chan_code_mid, chan_code_lsb} == displayChan)
    else $error("code lines differ from selected channel");
  a_chan_in_range: assert property (
    displayChan <= 3'h4) else $error("channel beyond four");
  a_curve_pos_map: assert property (
    curvePos == displayChan) else $error("remote position differs from channel");
  a_rdata_one_cycle: assert property (
    !$past(regRead) |-> regRdata == 8'h00) else $error("read data outside its cycle");
  a_volt_break_first: assert property (
    voltagePoles != $past(voltagePoles)
      |-> (voltagePoles == 5'h00 || $past(voltagePoles) == 5'h00))
    else $error("voltage poles swapped without break");
  a_volt_never_overlap: assert property (
    $onehot0(voltagePoles)) else $error("two voltage poles closed");
  a_cur_make_first: assert property (
    (currentPoles != $past(currentPoles) && $past(currentPoles) != 5'h00)
      |-> (currentPoles & $past(currentPoles)) != 5'h00)
    else $error("current poles swapped without make");
  a_cur_loop_closed: assert property (
    !$past(rst) |-> currentPoles != 5'h00) else $error("current loop opened");
  a_curve_off_closed: assert property (
    idSwitchBit4 [*4] |=> !curvePosValid) else $error("curve position used with switch closed");
  a_curve_on_open: assert property (
    (!idSwitchBit4) [*4] |=> curvePosValid) else $error("curve position unused with switch open");
endmodule : scs_channel_select_checker
bind scs_channel_select scs_channel_select_checker scs_channel_select_checker_inst (
  .clk_sys(clk_sys), .rst(rst), .idSwitchBit4(idSwitchBit4), .regRead(regRead),
  .regRdata(regRdata), .chan_code_lsb(chan_code_lsb), .chan_code_mid(chan_code_mid),
  .chan_code_msb(chan_code_msb), .displayChan(displayChan), .curvePos(curvePos),
  .curvePosValid(curvePosValid), .currentPoles(currentPoles), .voltagePoles(voltagePoles));

// >>> verification/scs_sensor_rec_model.sv
// Far side: recorder reading the code lines, sensor loop, input-card switch
`timescale 1ns/1ns
module scs_sensor_rec_model (
  input  wire logic       chan_code_lsb,
  input  wire logic       chan_code_mid,
  input  wire logic       chan_code_msb,
  input  wire logic [4:0] currentPoles,
  input  wire logic       idOpen,
  output logic      [2:0] recChan,
  output logic            loopIntact,
  output logic            idSwitchBit4
);
  // High reads one, first line lsb
  assign recChan = {chan_code_msb, chan_code_mid, chan_code_lsb};
  assign loopIntact = |currentPoles;
  assign idSwitchBit4 = !idOpen;
endmodule : scs_sensor_rec_model

// >>> verification/tb_top.sv
// Testbench for the scanner channel selector
`timescale 1ns/1ns
`include "scs_defs.svh"
module tb_top;
  import scs_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       keyAdvance = 1'b0;
  logic       idOpen = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic [7:0] regRdata;
  logic       idSwitchBit4, lsb, mid, msb, curvePosValid, loopIntact;
  logic [2:0] displayChan, curvePos, recChan;
  logic [4:0] currentPoles, voltagePoles;
  int         err_count = 0;
  int         compares = 0;
  always #25 clk_sys = ~clk_sys;
  scs_channel_select scs_channel_select_inst (.clk_sys(clk_sys), .rst(rst),
    .keyAdvance(keyAdvance), .idSwitchBit4(idSwitchBit4), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .chan_code_lsb(lsb), .chan_code_mid(mid), .chan_code_msb(msb),
    .displayChan(displayChan), .curvePos(curvePos), .curvePosValid(curvePosValid),
    .currentPoles(currentPoles), .voltagePoles(voltagePoles));
  scs_sensor_rec_model scs_sensor_rec_model_inst (.chan_code_lsb(lsb), .chan_code_mid(mid),
    .chan_code_msb(msb), .currentPoles(currentPoles), .idOpen(idOpen), .recChan(recChan),
    .loopIntact(loopIntact), .idSwitchBit4(idSwitchBit4));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chkReg
  task automatic chkPin(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask : chkPin
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    d = regRdata;
  endtask : rd
  task automatic waitIdle();
    logic [7:0] s;
    int         n;
    n = 0;
    s = 8'hff;
    repeat (16) @(posedge clk_sys);
    while (s[`SCS_STAT_BUSY] !== 1'b0 && n < 2000) begin
      rd(`SCS_ADDR_STAT, s);
      n++;
    end
    if (n >= 2000) err_count++;
  endtask : waitIdle
  task automatic settled(input logic [2:0] ch);
    chkPin({5'h00, recChan}, {5'h00, ch});
    chkPin({5'h00, displayChan}, {5'h00, ch});
    chkPin({5'h00, curvePos}, {5'h00, ch});
    chkPin({3'h0, currentPoles}, {3'h0, 5'h01 << ch});
    chkPin({3'h0, voltagePoles}, {3'h0, 5'h01 << ch});
  endtask : settled
  task automatic keyPress();
    @(posedge clk_sys);
    keyAdvance <= 1'b1;
    repeat (4) @(posedge clk_sys);
    keyAdvance <= 1'b0;
    waitIdle();
  endtask : keyPress
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    err_count++;
    complete_run();
  end
  initial begin
    logic [7:0] v;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    settled(3'h0);
    rd(`SCS_ADDR_STAT, v);
    chkReg(v, 8'h00);
    chkPin({7'h00, curvePosValid}, 8'h01);
    @(posedge clk_sys);
    idOpen <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rd(`SCS_ADDR_STAT, v);
    chkReg(v, 8'h10);
    chkPin({7'h00, curvePosValid}, 8'h00);
    @(posedge clk_sys);
    idOpen <= 1'b1;
    $display("test reset and switch done");
    wr(`SCS_ADDR_CTRL, 8'h24);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chkPin({3'h0, currentPoles}, 8'h05);
    chkPin({3'h0, voltagePoles}, 8'h00);
    chkPin({7'h00, loopIntact}, 8'h01);
    rd(`SCS_ADDR_STAT, v);
    chkReg(v, 8'h0a);
    waitIdle();
    settled(3'h2);
    wr(`SCS_ADDR_CTRL, 8'h54);
    rd(`SCS_ADDR_STAT, v);
    chkReg(v, 8'h02);
    rd(`SCS_ADDR_CTRL, v);
    chkReg(v, 8'h20);
    $display("test direct select done");
    keyPress();
    settled(3'h3);
    keyPress();
    settled(3'h4);
    keyPress();
    settled(3'h0);
    $display("test key wrap done");
    wr(`SCS_ADDR_DWELL0 + 4'h1, 8'hff);
    rd(`SCS_ADDR_DWELL0 + 4'h1, v);
    chkReg(v, 8'h63);
    wr(`SCS_ADDR_DWELL0, 8'h00);
    wr(`SCS_ADDR_CTRL, 8'h01);
    waitIdle();
    rd(`SCS_ADDR_CTRL, v);
    chkReg(v, 8'h11);
    settled(3'h1);
    wr(`SCS_ADDR_CTRL, 8'h02);
    waitIdle();
    settled(3'h2);
    rd(4'hf, v);
    chkReg(v, 8'h00);
    $display("test scan done");
    complete_run();
  end
endmodule : tb_top
